// >>> inc/amc_pkg.sv
// register map, field layout and defaults of the codec register bank
package amc_pkg;
  localparam int IDX_W = 7;
  localparam int DATA_W = 16;
  localparam int WORDS = 64;

  // register indices
  localparam logic [6:0] IDX_RESET = 7'h00;
  localparam logic [6:0] IDX_MASTER_VOL = 7'h02;
  localparam logic [6:0] IDX_HEADPHONE_VOL = 7'h04;
  localparam logic [6:0] IDX_BEEP_VOL = 7'h0A;
  localparam logic [6:0] IDX_MIC_VOL = 7'h0E;
  localparam logic [6:0] IDX_LINE_VOL = 7'h10;
  localparam logic [6:0] IDX_DISC_VOL = 7'h12;
  localparam logic [6:0] IDX_PCM_VOL = 7'h18;
  localparam logic [6:0] IDX_CAPT_SEL = 7'h1A;
  localparam logic [6:0] IDX_CAPT_GAIN = 7'h1C;
  localparam logic [6:0] IDX_LOOPBACK = 7'h20;
  localparam logic [6:0] IDX_POWER_DOWN = 7'h26;
  localparam logic [6:0] IDX_EXT_AUDIO_CAP = 7'h28;
  localparam logic [6:0] IDX_EXT_AUDIO_CTL = 7'h2A;
  localparam logic [6:0] IDX_FRONT_RATE = 7'h2C;
  localparam logic [6:0] IDX_LR_RATE = 7'h32;
  localparam logic [6:0] IDX_AUDIO_GROUP_END = 7'h38;
  localparam logic [6:0] IDX_EXT_MODEM_CAP = 7'h3C;
  localparam logic [6:0] IDX_EXT_MODEM_CTL = 7'h3E;
  localparam logic [6:0] IDX_LINE_RATE = 7'h40;
  localparam logic [6:0] IDX_PIN_DIR = 7'h4C;
  localparam logic [6:0] IDX_PIN_POL = 7'h4E;
  localparam logic [6:0] IDX_PIN_STICKY = 7'h50;
  localparam logic [6:0] IDX_PIN_WAKE = 7'h52;
  localparam logic [6:0] IDX_PIN_LEVEL = 7'h54;
  localparam logic [6:0] IDX_LINE_MISC = 7'h56;
  localparam logic [6:0] IDX_MIXER_GAIN = 7'h5A;
  localparam logic [6:0] IDX_AUDIO_MISC = 7'h5C;
  localparam logic [6:0] IDX_ISOLATION = 7'h66;
  localparam logic [6:0] IDX_COLD_MASK = 7'h68;
  localparam logic [6:0] IDX_CALLER_TIMEOUT = 7'h6A;
  localparam logic [6:0] IDX_MAKER_RSVD_FIRST = 7'h72;
  localparam logic [6:0] IDX_MAKER_RSVD_LAST = 7'h76;
  localparam logic [6:0] IDX_INDEXED = 7'h7A;
  localparam logic [6:0] IDX_MAKER_LOW = 7'h7C;
  localparam logic [6:0] IDX_MAKER_HIGH = 7'h7E;

  // capability code bit positions
  localparam int CAP_20BIT_INPUT_CONV = 9;
  localparam int CAP_18BIT_INPUT_CONV = 8;
  localparam int CAP_20BIT_OUTPUT_CONV = 7;
  localparam int CAP_18BIT_OUTPUT_CONV = 6;
  localparam int CAP_LOUDNESS = 5;
  localparam int CAP_HEADPHONE_OUT = 4;
  localparam int CAP_SIMULATED_STEREO = 3;
  localparam int CAP_TONE_CONTROL = 2;
  localparam int CAP_LINE_CODEC = 1;
  localparam int CAP_DEDICATED_MIC_CHANNEL = 0;
  localparam int ENH_MSB = 14;
  localparam int ENH_LSB = 10;
  localparam logic [4:0] STEREO_ENHANCE_CODE = 5'h00;
  localparam logic [15:0] CAP_CODE = (16'h0001 << CAP_18BIT_INPUT_CONV)
    | (16'h0001 << CAP_18BIT_OUTPUT_CONV) | (16'h0001 << CAP_HEADPHONE_OUT)
    | (16'h0001 << CAP_LINE_CODEC)
    | ({11'h000, STEREO_ENHANCE_CODE} << ENH_LSB);

  // volume field layout
  localparam int MUTE_BIT = 15;
  localparam int LEFT_MSB = 12;
  localparam int LEFT_LSB = 8;
  localparam int RIGHT_MSB = 4;
  localparam int RIGHT_LSB = 0;
  localparam int MIC_ROUTE_BIT = 6;

  localparam logic [15:0] VOL_MASK = 16'h9F1F;
  localparam logic [15:0] MUTED_DEFAULT = 16'h8000;
  localparam logic [15:0] ZERO16 = 16'h0000;

  function automatic logic [15:0] reg_wmask(input logic [6:0] idx);
    case (idx)
      IDX_MASTER_VOL, IDX_HEADPHONE_VOL: reg_wmask = VOL_MASK;
      IDX_BEEP_VOL: reg_wmask = 16'h8000;
      IDX_MIC_VOL: reg_wmask = 16'h805F;
      IDX_LINE_VOL, IDX_DISC_VOL, IDX_PCM_VOL: reg_wmask = VOL_MASK;
      IDX_CAPT_SEL: reg_wmask = 16'h0707;
      IDX_CAPT_GAIN: reg_wmask = 16'h8F0F;
      IDX_LOOPBACK: reg_wmask = 16'h0080;
      IDX_POWER_DOWN: reg_wmask = 16'h7F80;
      IDX_EXT_AUDIO_CTL: reg_wmask = 16'h0001;
      IDX_FRONT_RATE, IDX_LR_RATE, IDX_LINE_RATE: reg_wmask = 16'hFFFF;
      IDX_EXT_MODEM_CTL: reg_wmask = 16'h0100;
      IDX_PIN_DIR, IDX_PIN_POL, IDX_PIN_STICKY, IDX_PIN_WAKE: reg_wmask = 16'h0030;
      IDX_LINE_MISC: reg_wmask = 16'h1000;
      IDX_MIXER_GAIN: reg_wmask = 16'h0F0F;
      IDX_AUDIO_MISC: reg_wmask = 16'h077F;
      IDX_ISOLATION: reg_wmask = 16'h1128;
      IDX_COLD_MASK, IDX_INDEXED: reg_wmask = 16'hFFFF;
      IDX_CALLER_TIMEOUT: reg_wmask = 16'h00FF;
      default: reg_wmask = ZERO16;
    endcase
  endfunction

  function automatic logic [15:0] reg_default(input logic [6:0] idx);
    case (idx)
      IDX_MASTER_VOL, IDX_HEADPHONE_VOL, IDX_CAPT_GAIN: reg_default = MUTED_DEFAULT;
      IDX_MIC_VOL: reg_default = 16'h8008;
      IDX_LINE_VOL, IDX_DISC_VOL, IDX_PCM_VOL: reg_default = 16'h8808;
      IDX_POWER_DOWN: reg_default = 16'h4000;
      IDX_FRONT_RATE, IDX_LR_RATE, IDX_LINE_RATE: reg_default = 16'hBB80;
      IDX_EXT_MODEM_CTL: reg_default = 16'h0100;
      IDX_PIN_DIR: reg_default = 16'h0030;
      IDX_PIN_POL: reg_default = 16'hFFFF;
      IDX_AUDIO_MISC: reg_default = 16'h0600;
      IDX_CALLER_TIMEOUT: reg_default = 16'h0040;
      IDX_INDEXED: reg_default = 16'h8000;
      default: reg_default = ZERO16;
    endcase
  endfunction

  function automatic logic in_audio_group(input logic [6:0] idx);
    in_audio_group = (idx <= IDX_AUDIO_GROUP_END) || (idx == IDX_MIXER_GAIN)
      || (idx == IDX_AUDIO_MISC);
  endfunction
endpackage

// >>> hw/amc_register_bank.sv
// codec control and status register bank behind the link command slots
module amc_register_bank
  import amc_pkg::*;
#(
  parameter logic [15:0] MAKER_ID_LOW = 16'h0A0A, // arbitrary value
  parameter logic [15:0] MAKER_ID_HIGH = 16'h0B0B // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register command from link slot decoder
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  // register read answer
  output logic rsp_valid,
  output logic [6:0] rsp_index,
  output logic [15:0] rsp_data,
  // pin levels from outside
  input wire logic [7:0] pin_level_in,
  // controls to the mixer and converters
  output logic register_reset_pulse,
  output logic master_mute,
  output logic [4:0] master_left_attenuation,
  output logic [4:0] master_right_attenuation,
  output logic headphone_mute,
  output logic [4:0] headphone_left_attenuation,
  output logic [4:0] headphone_right_attenuation,
  output logic beep_mute,
  output logic microphone_route_select
);

  logic [15:0] regs [WORDS];
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [15:0] next_rdata;
  logic wr_en;
  logic rd_en;

  assign wr_en = cmd_valid && !cmd_read;
  assign rd_en = cmd_valid && cmd_read;

  // pin levels cross from outside
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_level_in;
      pin_sync <= pin_meta;
    end
  end

  // register storage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < WORDS; i++) begin
        regs[i] <= reg_default(7'(2 * i));
      end
    end else if (wr_en && cmd_index == IDX_RESET) begin
      for (int i = 0; i < WORDS; i++) begin
        if (in_audio_group(7'(2 * i))) begin
          regs[i] <= reg_default(7'(2 * i));
        end
      end
    end else if (wr_en) begin
      // masked write keeps reserved bits at their stored value, the reset default
      regs[cmd_index[6:1]] <= (regs[cmd_index[6:1]] & ~reg_wmask(cmd_index))
        | (cmd_wdata & reg_wmask(cmd_index));
    end
  end

  // register reset notice
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      register_reset_pulse <= 1'b0;
    end else begin
      register_reset_pulse <= wr_en && (cmd_index == IDX_RESET);
    end
  end

  // read data selection
  always_comb begin
    case (cmd_index)
      IDX_RESET: next_rdata = CAP_CODE;
      IDX_EXT_AUDIO_CAP: next_rdata = 16'h0201;
      IDX_EXT_MODEM_CAP: next_rdata = 16'h0001;
      IDX_PIN_LEVEL: next_rdata = {8'h00, pin_sync};
      IDX_MAKER_LOW: next_rdata = MAKER_ID_LOW;
      IDX_MAKER_HIGH: next_rdata = MAKER_ID_HIGH;
      default: next_rdata = regs[cmd_index[6:1]] & reg_wmask(cmd_index);
    endcase
  end

  // read answer, one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_index <= 7'h00;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= rd_en;
      if (rd_en) begin
        rsp_index <= cmd_index;
        rsp_data <= next_rdata;
      end
    end
  end

  // control fields to the analog path
  assign master_mute = regs[IDX_MASTER_VOL[6:1]][MUTE_BIT];
  assign master_left_attenuation = regs[IDX_MASTER_VOL[6:1]][LEFT_MSB:LEFT_LSB];
  assign master_right_attenuation = regs[IDX_MASTER_VOL[6:1]][RIGHT_MSB:RIGHT_LSB];
  assign headphone_mute = regs[IDX_HEADPHONE_VOL[6:1]][MUTE_BIT];
  assign headphone_left_attenuation = regs[IDX_HEADPHONE_VOL[6:1]][LEFT_MSB:LEFT_LSB];
  assign headphone_right_attenuation =
    regs[IDX_HEADPHONE_VOL[6:1]][RIGHT_MSB:RIGHT_LSB];
  assign beep_mute = regs[IDX_BEEP_VOL[6:1]][MUTE_BIT];
  assign microphone_route_select = regs[IDX_AUDIO_MISC[6:1]][MIC_ROUTE_BIT];

  // checks
  chk_reset_restores: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_RESET |=> master_mute && headphone_mute && !beep_mute
      && master_left_attenuation == 5'h00 && register_reset_pulse)
    else $error("register reset did not restore audio defaults");
  chk_reset_spares_modem: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_RESET
      |=> regs[IDX_CALLER_TIMEOUT[6:1]] == $past(regs[IDX_CALLER_TIMEOUT[6:1]]))
    else $error("register reset touched a modem register");
  chk_cap_code_read: assert property (@(posedge clk) disable iff (reset)
    rd_en && cmd_index == IDX_RESET |=> rsp_valid && rsp_data[ENH_MSB:ENH_LSB] == 5'h00
      && rsp_data[15] == 1'b0)
    else $error("capability read shows enhancement or bit 15");
  chk_cap_converters: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_RESET |-> rsp_data[9:6] == 4'h5)
    else $error("converter capability bits wrong");
  chk_cap_output_bits: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_RESET |-> rsp_data[CAP_18BIT_OUTPUT_CONV]
      && !rsp_data[CAP_20BIT_OUTPUT_CONV])
    else $error("output converter capability wrong");
  chk_cap_features: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_RESET |-> rsp_data[5:2] == 4'h4)
    else $error("feature capability bits wrong");
  chk_cap_after_reset: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_RESET ##1 rd_en && cmd_index == IDX_RESET
      |=> rsp_data[CAP_LINE_CODEC] && !rsp_data[CAP_DEDICATED_MIC_CHANNEL])
    else $error("line codec bit lost after register reset");
  chk_mic_route: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_AUDIO_MISC |=> microphone_route_select == $past(cmd_wdata[6]))
    else $error("mic route select did not follow write");
  chk_master_write: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_MASTER_VOL |=> master_mute == $past(cmd_wdata[15])
      && master_right_attenuation == $past(cmd_wdata[4:0]))
    else $error("master volume did not follow write");
  chk_no_sixth_bit: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && (rsp_index == IDX_MASTER_VOL || rsp_index == IDX_HEADPHONE_VOL)
      |-> rsp_data[5] == 1'b0 && rsp_data[13] == 1'b0)
    else $error("attenuation sixth bit visible");
  chk_headphone_write: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_HEADPHONE_VOL ##1 rd_en && cmd_index == IDX_HEADPHONE_VOL
      |=> rsp_data == ($past(cmd_wdata, 2) & VOL_MASK))
    else $error("headphone readback wrong");
  chk_beep_reserved: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_BEEP_VOL |-> rsp_data[14:0] == 15'h0000)
    else $error("beep reserved bits visible");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_MIC_VOL |-> (rsp_data & ~16'h805F) == 16'h0000)
    else $error("reserved bits read nonzero");
  chk_beep_write: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_BEEP_VOL |=> beep_mute == $past(cmd_wdata[MUTE_BIT]))
    else $error("beep mute did not follow write");
  chk_master_left: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_MASTER_VOL
      |=> master_left_attenuation == $past(cmd_wdata[LEFT_MSB:LEFT_LSB]))
    else $error("master left attenuation did not follow write");
  chk_headphone_fields: assert property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_HEADPHONE_VOL |=> headphone_mute == $past(cmd_wdata[MUTE_BIT])
      && headphone_left_attenuation == $past(cmd_wdata[LEFT_MSB:LEFT_LSB])
      && headphone_right_attenuation == $past(cmd_wdata[RIGHT_MSB:RIGHT_LSB]))
    else $error("headphone fields did not follow write");
  chk_pulse_source: assert property (@(posedge clk) disable iff (reset)
    !(wr_en && cmd_index == IDX_RESET) |=> !register_reset_pulse)
    else $error("register reset notice without a reset write");
  chk_pin_level_read: assert property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_PIN_LEVEL |-> rsp_data[15:8] == 8'h00)
    else $error("pin level upper byte nonzero");
  cov_register_reset: cover property (@(posedge clk) disable iff (reset)
    wr_en && cmd_index == IDX_MASTER_VOL ##[1:10] wr_en && cmd_index == IDX_RESET);
  cov_pin_read: cover property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_PIN_LEVEL);
  cov_unmute_master: cover property (@(posedge clk) disable iff (reset)
    $fell(master_mute));
  cov_cap_read: cover property (@(posedge clk) disable iff (reset)
    rsp_valid && rsp_index == IDX_RESET);

endmodule // amc_register_bank

// >>> bench/amc_ctrl_model.sv
// controller model issuing register commands on the decoded link slot
module amc_ctrl_model
  import amc_pkg::*;
(
  // clock
  input wire logic clk,
  // command toward the register bank
  output logic cmd_valid,
  output logic cmd_read,
  output logic [6:0] cmd_index,
  output logic [15:0] cmd_wdata,
  // read answer
  input wire logic rsp_valid,
  input wire logic [6:0] rsp_index,
  input wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_index = 7'h00;
    cmd_wdata = 16'h0000;
  end

  // one command, held over exactly one taking edge
  task automatic send(input logic rd, input logic [6:0] idx, input logic [15:0] data);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_index = idx;
    cmd_wdata = (!rd && idx == IDX_RESET) ? (data & 16'h7FFF) : data;
    @(negedge clk);
  endtask

  task automatic read(input logic [6:0] idx, output logic ok, output logic [6:0] ri,
                      output logic [15:0] rdat);
    send(1'b1, idx, ~cmd_wdata);
    ok = rsp_valid;
    ri = rsp_index;
    rdat = rsp_data;
  endtask

  // idle inverts the fields, which stop showing the last command and show it again after a second idle in a row
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_read = ~cmd_read;
    cmd_index = ~cmd_index;
    cmd_wdata = ~cmd_wdata;
    @(negedge clk);
  endtask
endmodule // amc_ctrl_model

// >>> bench/tb.sv
// self-checking bench for the codec register bank
module tb
  import amc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset, cmd_valid, cmd_read, rsp_valid, register_reset_pulse;
  logic [6:0] cmd_index, rsp_index;
  logic [15:0] cmd_wdata, rsp_data;
  logic [7:0] pin_level_in;
  logic master_mute, headphone_mute, beep_mute, microphone_route_select;
  logic [4:0] master_left_attenuation, master_right_attenuation;
  logic [4:0] headphone_left_attenuation, headphone_right_attenuation;
  int seed = 32'h6EA7;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] mdl [logic [6:0]];
  logic [6:0] idx_list [10] = '{7'h00, 7'h02, 7'h04, 7'h0A, 7'h40, 7'h5A, 7'h5C, 7'h06, 7'h72,
    7'h0E};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  amc_register_bank dut (.clk, .reset, .cmd_valid, .cmd_read, .cmd_index, .cmd_wdata,
    .rsp_valid, .rsp_index, .rsp_data, .pin_level_in, .register_reset_pulse,
    .master_mute, .master_left_attenuation, .master_right_attenuation, .headphone_mute,
    .headphone_left_attenuation, .headphone_right_attenuation, .beep_mute,
    .microphone_route_select);

  amc_ctrl_model ctrl (.clk, .cmd_valid, .cmd_read, .cmd_index, .cmd_wdata, .rsp_valid,
    .rsp_index, .rsp_data);

  function automatic logic [15:0] wmask(input logic [6:0] i);
    case (i)
      7'h02, 7'h04: return 16'h9F1F;
      7'h0A: return 16'h8000;
      7'h0E: return 16'h805F;
      7'h40: return 16'hFFFF;
      7'h5A: return 16'h0F0F;
      7'h5C: return 16'h077F;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] dflt(input logic [6:0] i);
    case (i)
      7'h00: return 16'h0152;
      7'h02, 7'h04: return 16'h8000;
      7'h40: return 16'hBB80;
      7'h0E: return 16'h8008;
      7'h5C: return 16'h0600;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic mdl_write(input logic [6:0] i, input logic [15:0] d);
    if (i == 7'h00) begin
      foreach (idx_list[k]) begin
        if (idx_list[k] <= 7'h38 || idx_list[k] == 7'h5A || idx_list[k] == 7'h5C)
          mdl[idx_list[k]] = dflt(idx_list[k]);
      end
    end else
      mdl[i] = (mdl[i] & ~wmask(i)) | (d & wmask(i));
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_ctrl();
    chk_word("master", mdl[7'h02], {master_mute, 2'b00, master_left_attenuation, 3'b000,
      master_right_attenuation});
    chk_word("headphone", mdl[7'h04], {headphone_mute, 2'b00, headphone_left_attenuation,
      3'b000, headphone_right_attenuation});
    chk_bit("beep mute", mdl[7'h0A][15], beep_mute);
    chk_bit("mic route", mdl[7'h5C][6], microphone_route_select);
  endtask

  task automatic rd_chk(input logic [6:0] i);
    logic ok;
    logic [6:0] ri;
    logic [15:0] d;
    ctrl.read(i, ok, ri, d);
    chk_bit("rsp_valid", 1'b1, ok);
    chk_word("rsp_index", {9'h000, i}, {9'h000, ri});
    chk_word("read data", mdl[i], d);
  endtask

  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    results();
  end

  initial begin
    logic [6:0] i;
    logic [15:0] d;
    reset = 1'b1;
    pin_level_in = 8'h00;
    foreach (idx_list[k]) mdl[idx_list[k]] = dflt(idx_list[k]);
    repeat (8) @(negedge clk);
    reset = 1'b0;
    check_ctrl();
    foreach (idx_list[k]) rd_chk(idx_list[k]);
    ctrl.idle();
    $display("test defaults done");
    repeat (60) begin
      i = idx_list[$unsigned($random(seed)) % 10];
      d = 16'($random(seed));
      pin_level_in = 8'($random(seed));
      ctrl.send(1'b0, i, d);
      mdl_write(i, d);
      check_ctrl();
      rd_chk(i);
    end
    ctrl.idle();
    $display("test random access done");
    pin_level_in = 8'($random(seed));
    mdl[7'h54] = {8'h00, pin_level_in};
    ctrl.idle();
    ctrl.idle();
    rd_chk(7'h54);
    ctrl.idle();
    $display("test pin levels done");
    for (int k = 1; k < 10; k++) begin
      ctrl.send(1'b0, idx_list[k], 16'hFFFF);
      mdl_write(idx_list[k], 16'hFFFF);
    end
    ctrl.send(1'b0, 7'h00, 16'hFFFF);
    mdl_write(7'h00, 16'hFFFF);
    chk_bit("reset pulse", 1'b1, register_reset_pulse);
    check_ctrl();
    ctrl.idle();
    chk_bit("reset pulse", 1'b0, register_reset_pulse);
    foreach (idx_list[k]) rd_chk(idx_list[k]);
    ctrl.idle();
    $display("test register reset done");
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    foreach (idx_list[k]) mdl[idx_list[k]] = dflt(idx_list[k]);
    chk_bit("rsp_valid idle", 1'b0, rsp_valid);
    chk_bit("reset pulse", 1'b0, register_reset_pulse);
    check_ctrl();
    foreach (idx_list[k]) rd_chk(idx_list[k]);
    ctrl.idle();
    $display("test mid-run reset done");
    results();
  end
endmodule // tb
